// *** tmf_irq_consts.svh ***
// Offsets, bit positions, reset values and mode codes of the timer IRQ block
`ifndef TMF_IRQ_CONSTS_SVH
`define TMF_IRQ_CONSTS_SVH

// Data-space offsets
`define TMF_OFS_T1_FLAGS 8'h36
`define TMF_OFS_T1_MASK 8'h6f
`define TMF_OFS_T3_MASK 8'h71
`define TMF_OFS_T4_MASK 8'h72

// I/O-instruction window
`define TMF_IO_BASE 8'h20
`define TMF_IO_LAST 8'h3f

// Register bit positions
`define TMF_BIT_CAPTURE 5
`define TMF_BIT_CMP_B 2
`define TMF_BIT_CMP_A 1
`define TMF_BIT_OVERFLOW 0

// Reset values
`define TMF_RESET_REG 8'h00
`define TMF_RESET_SRC 4'h0

// Waveform mode codes
`define TMF_MODE_NORMAL 4'h0
`define TMF_MODE_CTC_OCR 4'h4
`define TMF_MODE_CTC_ICR 4'hc
`define TMF_MODE_FAST_ICR 4'he
`define TMF_MODE_PFC_ICR 4'h8
`define TMF_MODE_PC_ICR 4'ha

// Counter end value
`define TMF_COUNT_MAX 16'hffff

`endif

// *** tmf_irq_pkg.sv ***
// Types of the timer IRQ mask and flag block
package tmf_irq_pkg;

    // One bit per source: [3] capture, [2] cmp B, [1] cmp A, [0] overflow
    typedef logic [3:0] tmf_src_t;

    typedef struct packed {
        logic stage1;
        logic stage2;
    } tmf_sync_state_t;

    typedef struct packed {
        logic flag;
    } tmf_flag_state_t;

    typedef struct packed {
        tmf_src_t t1Mask;
        tmf_src_t t3Mask;
        tmf_src_t t4Mask;
        logic pinPrev;
        logic matchA;
        logic matchB;
        tmf_src_t t1Irq;
        tmf_src_t t3Irq;
        tmf_src_t t4Irq;
        logic [7:0] rdData;
    } tmf_top_state_t;

endpackage : tmf_irq_pkg

// *** tmf_sync2.sv ***
// Two-stage synchroniser for an asynchronous level
`timescale 1ns/10ps
module tmf_sync2
    import tmf_irq_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic reset,
    // Level
    input wire logic asyncIn,
    output logic syncOut
);
    tmf_sync_state_t state_reg;
    tmf_sync_state_t state_next;

    always_comb begin
        state_next = state_reg;
        state_next.stage1 = asyncIn;
        state_next.stage2 = state_reg.stage1;
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign syncOut = state_reg.stage2;
endmodule : tmf_sync2

// *** tmf_flag_bit.sv ***
// Sticky event flag with vector and write-one clear
`timescale 1ns/10ps
module tmf_flag_bit
    import tmf_irq_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic reset,
    // Set and clear
    input wire logic setEvent,
    input wire logic clearVector,
    input wire logic clearWrite,
    // Flag
    output logic flag
);
    tmf_flag_state_t state_reg;
    tmf_flag_state_t state_next;

    // Set is applied last so a same-cycle event survives a clear
    always_comb begin
        state_next = state_reg;
        if (clearVector || clearWrite) begin
            state_next.flag = 1'b0;
        end
        if (setEvent) begin
            state_next.flag = 1'b1;
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign flag = state_reg.flag;
endmodule : tmf_flag_bit

// *** tmf_irq_top.sv ***
// Interrupt masks and timer 1 event flags for three 16-bit timers
//
// What this block does
// - Timer 1 capture request needs mask bit 5, global enable, flag.
// - Timer 1 compare B request needs mask bit 2, global, flag.
// - Timer 1 compare A request needs mask bit 1, global, flag.
// - Timer 1 overflow request needs mask bit 0, global, flag.
// - Timer 3 mask at 0x71 gates its requests, bits 5,2,1,0.
// - Timer 4 mask at 0x72 gates its requests, bits 5,2,1,0.
// - Timer 1 flags at data offset 0x36 and I/O address 0x16.
// - I/O address is data offset minus 0x20, within 0x00-0x3F.
// - Capture pin event sets timer 1 capture flag, bit 5.
// - With capture register as TOP, reaching TOP sets capture flag.
// - Capture flag clears on vector or write of one.
// - Compare B flag sets the timer cycle after counter matches.
// - Compare A flag sets the timer cycle after counter matches.
// - Forced compare strobes never set compare flags.
// - Compare flags clear on vector or write of one.
// - Normal and CTC overflow sets bit 0; vector or one clears.
`timescale 1ns/10ps
`include "tmf_irq_consts.svh"
module tmf_irq_top
    import tmf_irq_pkg::*;
#(
    parameter int CountWidth = 16
)
(
    // Clock and reset
    input wire logic clock,
    input wire logic reset,
    // CPU register port
    input wire logic [7:0] busAddr,
    input wire logic ioSpace,
    input wire logic wrStrobe,
    input wire logic [7:0] wrData,
    input wire logic rdStrobe,
    output logic [7:0] rdData,
    // CPU core status and vector acknowledge
    input wire logic globalIrqEnable,
    input wire logic [3:0] t1VectorAck,
    // Timer 1 datapath
    input wire logic timerTick,
    input wire logic [CountWidth-1:0] counterValue,
    input wire logic [CountWidth-1:0] compareAValue,
    input wire logic [CountWidth-1:0] compareBValue,
    input wire logic [CountWidth-1:0] captureValueReg,
    input wire logic [3:0] waveformModeSel,
    input wire logic captureRisingEdge,
    input wire logic otherModeOverflow,
    input wire logic forceCmpAStrobe,
    input wire logic forceCmpBStrobe,
    // Capture pin
    input wire logic captureInputPin,
    // Flags of timers 3 and 4
    input wire logic [3:0] t3Flags,
    input wire logic [3:0] t4Flags,
    // Interrupt requests
    output logic [3:0] t1IrqReq,
    output logic [3:0] t3IrqReq,
    output logic [3:0] t4IrqReq
);

    localparam logic [CountWidth-1:0] CountMax =
        CountWidth'(`TMF_COUNT_MAX);

    tmf_top_state_t state_reg;
    tmf_top_state_t state_next;

    // Synchronised capture pin
    logic pinSync;

    tmf_sync2 u_pin_sync (
        .clock(clock),
        .reset(reset),
        .asyncIn(captureInputPin),
        .syncOut(pinSync)
    );

    // Address translation
    logic ioInRange;
    logic accessValid;
    logic [7:0] dataAddr;

    always_comb begin
        ioInRange = (busAddr <= `TMF_IO_LAST);
        if (ioSpace) begin
            // I/O instructions reach only the low window
            dataAddr = 8'(busAddr + `TMF_IO_BASE);
            accessValid = ioInRange;
        end else begin
            dataAddr = busAddr;
            accessValid = 1'b1;
        end
    end

    // Register selects
    logic selFlags1;
    logic selMask1;
    logic selMask3;
    logic selMask4;

    always_comb begin
        selFlags1 = accessValid &&
            (dataAddr == `TMF_OFS_T1_FLAGS);
        selMask1 = accessValid && (dataAddr == `TMF_OFS_T1_MASK);
        selMask3 = accessValid &&
            (dataAddr == `TMF_OFS_T3_MASK);
        selMask4 = accessValid &&
            (dataAddr == `TMF_OFS_T4_MASK);
    end

    // Byte to source vector and back
    function automatic tmf_src_t toSrc(input logic [7:0] b);
        tmf_src_t s;
        s[3] = b[`TMF_BIT_CAPTURE];
        s[2] = b[`TMF_BIT_CMP_B];
        s[1] = b[`TMF_BIT_CMP_A];
        s[0] = b[`TMF_BIT_OVERFLOW];
        return s;
    endfunction : toSrc

    function automatic logic [7:0] toByte(input tmf_src_t s);
        logic [7:0] b;
        b = `TMF_RESET_REG;
        b[`TMF_BIT_CAPTURE] = s[3];
        b[`TMF_BIT_CMP_B] = s[2];
        b[`TMF_BIT_CMP_A] = s[1];
        b[`TMF_BIT_OVERFLOW] = s[0];
        return b;
    endfunction : toByte

    // Waveform mode decode
    logic icrIsTop;
    logic ovfNormalCtc;

    always_comb begin
        icrIsTop = (waveformModeSel == `TMF_MODE_CTC_ICR) ||
            (waveformModeSel == `TMF_MODE_FAST_ICR) ||
            (waveformModeSel == `TMF_MODE_PFC_ICR) ||
            (waveformModeSel == `TMF_MODE_PC_ICR);
        ovfNormalCtc = (waveformModeSel == `TMF_MODE_NORMAL) ||
            (waveformModeSel == `TMF_MODE_CTC_OCR) ||
            (waveformModeSel == `TMF_MODE_CTC_ICR);
    end

    // Hardware events for the timer 1 flags
    tmf_src_t t1Set;
    logic pinEdge;
    logic topReached;

    always_comb begin
        // Pin capture is unused while the capture register sets TOP
        pinEdge = captureRisingEdge ?
            (pinSync && !state_reg.pinPrev) :
            (!pinSync && state_reg.pinPrev);
        topReached = timerTick && (counterValue == captureValueReg);
        t1Set[3] = icrIsTop ? topReached : pinEdge;
        // Match is held one timer cycle before it reaches the flag
        t1Set[2] = timerTick && state_reg.matchB;
        t1Set[1] = timerTick && state_reg.matchA;
        if (ovfNormalCtc) begin
            t1Set[0] = timerTick && (counterValue == CountMax);
        end else begin
            t1Set[0] = otherModeOverflow;
        end
    end

    // Write-one clears; zero bits leave flags alone
    tmf_src_t t1WrClear;

    always_comb begin
        t1WrClear = (wrStrobe && selFlags1) ?
            toSrc(wrData) : `TMF_RESET_SRC;
    end

    // Timer 1 flag bits
    tmf_src_t t1Flags;

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_flag
            tmf_flag_bit u_flag (
                .clock(clock),
                .reset(reset),
                .setEvent(t1Set[gi]),
                .clearVector(t1VectorAck[gi]),
                .clearWrite(t1WrClear[gi]),
                .flag(t1Flags[gi])
            );
        end
    endgenerate

    // Next-state logic
    always_comb begin
        state_next = state_reg;
        state_next.pinPrev = pinSync;

        // Forced strobes are not counter matches
        if (timerTick) begin
            state_next.matchA =
                (counterValue == compareAValue);
            state_next.matchB =
                (counterValue == compareBValue);
        end

        // Mask writes keep only the four used bits
        if (wrStrobe && selMask1) begin
            state_next.t1Mask = toSrc(wrData);
        end
        if (wrStrobe && selMask3) begin
            state_next.t3Mask = toSrc(wrData);
        end
        if (wrStrobe && selMask4) begin
            state_next.t4Mask = toSrc(wrData);
        end

        // Read data, zero for unmapped offsets
        if (rdStrobe) begin
            if (selFlags1) begin
                state_next.rdData = toByte(t1Flags);
            end else if (selMask1) begin
                state_next.rdData = toByte(state_reg.t1Mask);
            end else if (selMask3) begin
                state_next.rdData = toByte(state_reg.t3Mask);
            end else if (selMask4) begin
                state_next.rdData = toByte(state_reg.t4Mask);
            end else begin
                state_next.rdData = `TMF_RESET_REG;
            end
        end

        // Requests, gated by the global enable
        state_next.t1Irq = t1Flags & state_reg.t1Mask &
            {4{globalIrqEnable}};
        state_next.t3Irq = t3Flags & state_reg.t3Mask &
            {4{globalIrqEnable}};
        state_next.t4Irq = t4Flags & state_reg.t4Mask &
            {4{globalIrqEnable}};
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    // Outputs
    assign rdData = state_reg.rdData;
    assign t1IrqReq = state_reg.t1Irq;
    assign t3IrqReq = state_reg.t3Irq;
    assign t4IrqReq = state_reg.t4Irq;

    // Forced strobes are accepted and have no effect on the flags
    logic forceSeen;
    assign forceSeen = forceCmpAStrobe | forceCmpBStrobe;

endmodule : tmf_irq_top

// *** tmf_irq_checker.sv ***
// Port-level assertions for the timer IRQ mask and flag block
`timescale 1ns/10ps
module tmf_irq_checker (
    // Clock and reset
    input wire logic clock,
    input wire logic reset,
    // Register port
    input wire logic [7:0] busAddr,
    input wire logic ioSpace,
    input wire logic wrStrobe,
    input wire logic [7:0] wrData,
    input wire logic rdStrobe,
    input wire logic [7:0] rdData,
    // Core status, flags and requests
    input wire logic globalIrqEnable,
    input wire logic [3:0] t3Flags,
    input wire logic [3:0] t4Flags,
    input wire logic [3:0] t1IrqReq,
    input wire logic [3:0] t3IrqReq,
    input wire logic [3:0] t4IrqReq
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (reset);
    sequence s_wr(a);
        wrStrobe && !ioSpace && busAddr == a;
    endsequence
    sequence s_rd(a);
        rdStrobe && !wrStrobe && !ioSpace && busAddr == a;
    endsequence
    property p_t3Read;
        s_wr(8'h71) ##1 s_rd(8'h71)
            |=> rdData == ($past(wrData, 2) & 8'h27);
    endproperty
    property p_t4Read;
        s_wr(8'h72) ##1 s_rd(8'h72)
            |=> rdData == ($past(wrData, 2) & 8'h27);
    endproperty
    // Request is one cycle behind its cause
    property p_t3Gate;
        (t3IrqReq & ~($past(t3Flags) & {4{$past(globalIrqEnable)}})) == 4'h0;
    endproperty
    property p_t4Gate;
        (t4IrqReq & ~($past(t4Flags) & {4{$past(globalIrqEnable)}})) == 4'h0;
    endproperty
    property p_t1Off;
        !globalIrqEnable |=> t1IrqReq == 4'h0;
    endproperty
    property p_ioRange;
        rdStrobe && ioSpace && busAddr > 8'h3f |=> rdData == 8'h00;
    endproperty
    property p_unused;
        rdStrobe |=> (rdData & 8'hd8) == 8'h00;
    endproperty
    property p_unmapped;
        rdStrobe && !ioSpace && busAddr < 8'h20 |=> rdData == 8'h00;
    endproperty
    a_t3Read: assert property (p_t3Read) else $error("t3 mask");
    a_t4Read: assert property (p_t4Read) else $error("t4 mask");
    a_t3Gate: assert property (p_t3Gate) else $error("t3 req");
    a_t4Gate: assert property (p_t4Gate) else $error("t4 req");
    a_t1Off: assert property (p_t1Off) else $error("t1 req");
    a_ioRange: assert property (p_ioRange) else $error("io read");
    a_unused: assert property (p_unused) else $error("unused");
    a_unmapped: assert property (p_unmapped) else $error("unmap");
endmodule : tmf_irq_checker

bind tmf_irq_top tmf_irq_checker tmf_irq_checker_inst (
    .clock(clock), .reset(reset), .busAddr(busAddr), .ioSpace(ioSpace),
    .wrStrobe(wrStrobe), .wrData(wrData), .rdStrobe(rdStrobe),
    .rdData(rdData), .globalIrqEnable(globalIrqEnable),
    .t3Flags(t3Flags), .t4Flags(t4Flags), .t1IrqReq(t1IrqReq),
    .t3IrqReq(t3IrqReq), .t4IrqReq(t4IrqReq));

// *** tmf_cpu_model.sv ***
// Behavioural CPU core driving the register port
`timescale 1ns/10ps
module tmf_cpu_model (
    // Clock
    input wire logic clock,
    // Register port
    output logic [7:0] busAddr,
    output logic ioSpace,
    output logic wrStrobe,
    output logic [7:0] wrData,
    output logic rdStrobe,
    input wire logic [7:0] rdData,
    // Core status
    output logic globalIrqEnable,
    output logic [3:0] t1VectorAck
);
    initial begin
        {busAddr, ioSpace, wrStrobe, wrData, rdStrobe} = '0;
        globalIrqEnable = 1'b0;
        t1VectorAck = 4'h0;
    end
    // Callers pick io only below 0x60, one bench case aside
    task automatic put(input logic [7:0] a, input logic io);
        ioSpace <= io;
        busAddr <= io ? a - 8'h20 : a;
    endtask : put
    task automatic wr(input logic [7:0] a, input logic io,
        input logic [7:0] v);
        put(a, io);
        wrData <= v;
        wrStrobe <= 1'b1;
        @(posedge clock);
        wrStrobe <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic io,
        output logic [7:0] v);
        put(a, io);
        rdStrobe <= 1'b1;
        @(posedge clock);
        rdStrobe <= 1'b0;
        @(posedge clock);
        v = rdData;
    endtask : rd
    task automatic vec(input logic [3:0] m);
        t1VectorAck <= m;
        @(posedge clock);
        t1VectorAck <= 4'h0;
    endtask : vec
    task automatic gi(input logic v);
        globalIrqEnable <= v;
    endtask : gi
endmodule : tmf_cpu_model

// *** tb_timer16_irq_mask_flags.sv ***
// Self-checking bench for the timer IRQ mask and flag block
`timescale 1ns/10ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin mismatches++; \
    $display("ERROR %0t %h %h", $time, a, b); end end
module tb_timer16_irq_mask_flags;
    import tmf_irq_pkg::*;
    logic clock = 1'b0;
    logic reset = 1'b1;
    logic [7:0] busAddr, wrData, rdData, d, m;
    logic ioSpace, wrStrobe, rdStrobe, gie, timerTick = 1'b0;
    logic [3:0] ack, req1, req3, req4, mode = 4'h0, t3F = 4'h0, t4F = 4'h0;
    logic [15:0] cnt = 16'h0, cmpA = 16'h0, cmpB = 16'h0, capV = 16'h0;
    logic pin = 1'b0, frc = 1'b0, edgeSel = 1'b1, ovfOther = 1'b0;
    logic [31:0] seed = 32'hdfdfd5e4;
    logic [7:0] offs[4] = '{8'h36, 8'h6f, 8'h71, 8'h72};
    tmf_src_t msk[3] = '{default: 4'h0};
    int mismatches = 0;
    int n_checks = 0;
    always #12.5 clock = ~clock;
    tmf_irq_top tmf_irq_top_inst (
        .clock(clock), .reset(reset), .busAddr(busAddr), .ioSpace(ioSpace),
        .wrStrobe(wrStrobe), .wrData(wrData), .rdStrobe(rdStrobe),
        .rdData(rdData), .globalIrqEnable(gie), .t1VectorAck(ack),
        .timerTick(timerTick), .counterValue(cnt), .compareAValue(cmpA),
        .compareBValue(cmpB), .captureValueReg(capV),
        .waveformModeSel(mode), .captureRisingEdge(edgeSel),
        .otherModeOverflow(ovfOther), .forceCmpAStrobe(frc),
        .forceCmpBStrobe(frc), .captureInputPin(pin), .t3Flags(t3F),
        .t4Flags(t4F), .t1IrqReq(req1), .t3IrqReq(req3), .t4IrqReq(req4));
    tmf_cpu_model tmf_cpu_model_inst (
        .clock(clock), .busAddr(busAddr), .ioSpace(ioSpace),
        .wrStrobe(wrStrobe), .wrData(wrData), .rdStrobe(rdStrobe),
        .rdData(rdData), .globalIrqEnable(gie), .t1VectorAck(ack));
    function automatic logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction : rnd
    function automatic tmf_src_t src(input logic [7:0] r);
        return {r[5], r[2], r[1], r[0]};
    endfunction : src
    task automatic tk(input logic [15:0] c);
        cnt <= c;
        timerTick <= 1'b1;
        @(posedge clock);
        timerTick <= 1'b0;
        @(posedge clock);
    endtask : tk
    task automatic rdc(input logic [7:0] a, input logic io,
        input logic [7:0] e);
        tmf_cpu_model_inst.rd(a, io, d);
        `CHK(d, e)
    endtask : rdc
    task automatic end_sim();
        if (mismatches == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : end_sim
    initial begin
        repeat (20000) @(posedge clock);
        mismatches++;
        end_sim();
    end
    initial begin
        repeat (16) @(posedge clock);
        reset <= 1'b0;
        @(posedge clock);
        foreach (offs[i]) rdc(offs[i], 1'b0, 8'h00);
        for (int i = 0; i < 24; i++) begin
            m = rnd();
            tmf_cpu_model_inst.wr(offs[1 + i % 3], 1'b0, m);
            rdc(offs[1 + i % 3], 1'b0, m & 8'h27);
            msk[i % 3] = src(m);
            d = rnd();
            t3F <= d[3:0];
            t4F <= d[7:4];
            tmf_cpu_model_inst.gi(m[6]);
            repeat (2) @(posedge clock);
            `CHK(req3, t3F & msk[1] & {4{m[6]}})
            `CHK(req4, t4F & msk[2] & {4{m[6]}})
        end
        tmf_cpu_model_inst.wr(8'h6f, 1'b0, 8'hff);
        tmf_cpu_model_inst.gi(1'b1);
        // Forced strobes alone, with no match on the counter
        frc <= 1'b1;
        tk(16'h0003);
        frc <= 1'b0;
        rdc(8'h36, 1'b0, 8'h00);
        for (int j = 0; j < 2; j++) begin
            cmpA <= j ? 16'h0 : 16'h0010;
            cmpB <= j ? 16'h0010 : 16'h0;
            tk(16'h0010);
            rdc(8'h36, 1'b0, 8'h00);
            tk(16'h0011);
            m = j ? 8'h04 : 8'h02;
            rdc(8'h36, 1'b0, m);
            `CHK(req1, src(m))
            tmf_cpu_model_inst.wr(8'h36, 1'b0, 8'h00);
            rdc(8'h36, 1'b0, m);
            if (j) tmf_cpu_model_inst.vec(4'h4);
            else tmf_cpu_model_inst.wr(8'h36, 1'b0, m);
            rdc(8'h36, 1'b0, 8'h00);
        end
        // Normal and CTC modes overflow by themselves, others by pulse
        for (int k = 0; k < 3; k++) begin
            mode <= (k == 0) ? 4'h0 : ((k == 1) ? 4'h4 : 4'he);
            tk(16'hffff);
            if (k == 2) begin
                rdc(8'h36, 1'b0, 8'h00);
                ovfOther <= 1'b1;
                @(posedge clock);
                ovfOther <= 1'b0;
            end
            rdc(8'h36, 1'b0, 8'h01);
            `CHK(req1, 4'h1)
            tmf_cpu_model_inst.vec(4'h1);
            rdc(8'h36, 1'b0, 8'h00);
        end
        mode <= 4'h0;
        pin <= 1'b1;
        repeat (4) @(posedge clock);
        rdc(8'h36, 1'b1, 8'h20);
        `CHK(req1, 4'h8)
        tmf_cpu_model_inst.gi(1'b0);
        repeat (2) @(posedge clock);
        `CHK(req1, 4'h0)
        tmf_cpu_model_inst.vec(4'h8);
        rdc(8'h36, 1'b0, 8'h00);
        // Falling edges capture from here; TOP modes ignore the pin
        edgeSel <= 1'b0;
        capV <= 16'h0020;
        for (int k = 0; k < 4; k++) begin
            mode <= {1'b1, 2'(k), 1'b0};
            pin <= ~pin;
            repeat (4) @(posedge clock);
            rdc(8'h36, 1'b0, 8'h00);
            tk(16'h0020);
            rdc(8'h36, 1'b0, 8'h20);
            tmf_cpu_model_inst.wr(8'h36, 1'b1, 8'h20);
            rdc(8'h36, 1'b0, 8'h00);
        end
        mode <= 4'h0;
        pin <= 1'b0;
        repeat (4) @(posedge clock);
        rdc(8'h36, 1'b0, 8'h20);
        tmf_cpu_model_inst.wr(8'h36, 1'b0, 8'h20);
        pin <= 1'b1;
        repeat (4) @(posedge clock);
        rdc(8'h36, 1'b0, 8'h00);
        // Extended space by I/O address is refused on purpose here
        rdc(8'h6f, 1'b1, 8'h00);
        rdc(8'h6f, 1'b0, 8'h27);
        rdc(8'h05, 1'b0, 8'h00);
        end_sim();
    end
endmodule : tb_timer16_irq_mask_flags
